// *** rtl/ccr_top.sv ***
// Purpose: calendar clock with bcd counters behind a wishbone slave
// Assumes: classic wishbone, byte registers in data bits 7:0
// Notes:   byte address is four times the register index
//
// Design decision made here: the Wishbone slave port.
`timescale 1ns/10ps
`default_nettype none

// Overview of operation
// - Seconds are two bcd digits in bits 6 to 0 and bit 7 reads zero.
// - Minutes are two bcd digits in bits 6 to 0 and bit 7 reads zero.
// - Hours sit in bits 5 to 0, bit 5 is twenty hours or the afternoon flag, 7 and 6 read zero.
// - On page zero the month sits in bits 4 to 0 as bcd and the rest reads zero.
// - On page one bit 0 at the month address picks 12-hour (0) or 24-hour (1) counting.
// - On page zero the year is a full eight-bit bcd value up to 99.
// - On page one bits 1 to 0 at the year address give the place in the four-year leap cycle.
// - The page register holds adjust, count enable, alarm enable, page select, and an irq enable reset to 0.
// - The reset register gates the 1 Hz and 16 Hz outputs and resets clock or alarm on a written 1.
module ccr_top
   import ccr_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = CCR_TICK_CYCLES
) (
   input  wire logic        clk_i,         // 40 MHz clock
   input  wire logic        rst_i,         // sync reset, high
   input  wire logic        cyc_i,         // bus cycle
   input  wire logic        stb_i,         // bus strobe
   input  wire logic        we_i,          // write enable
   input  wire logic [15:0] adr_i,         // byte address
   input  wire logic [3:0]  sel_i,         // byte lanes
   input  wire logic [31:0] dat_i,         // write data
   output logic      [31:0] dat_o,         // read data
   output logic             ack_o,         // bus acknowledge
   output logic             irq_o,         // level interrupt
   output logic             one_hz_o,      // gated 1 Hz wave
   output logic             sixteen_hz_o   // gated 16 Hz wave
);
   typedef struct packed {
      logic [7:0]          sec;
      logic [7:0]          min;
      logic [7:0]          hour;
      logic [7:0]          wday;
      logic [7:0]          mday;
      logic [7:0]          month;
      logic [7:0]          year;
      logic                h24;
      logic [1:0]          leap;
      logic                irq_en;
      logic                cnt_en;
      logic                alm_en;
      logic                page;
      logic                adj;
      logic                g1;
      logic                g16;
      logic                clr;
      logic [CCR_ST_W-1:0] status;
      logic [CCR_ST_W-1:0] mask;
      logic                ack;
      logic [7:0]          dat;
      logic                irq;
      logic                one_hz;
      logic                sixteen_hz;
   } ccr_state_t;

   ccr_state_t  s_q;
   ccr_state_t  s_d;
   logic        tick_w;
   logic        w1_w;
   logic        w16_w;
   logic        req;
   logic        wr;
   logic        rd;
   logic [13:0] idx;
   logic [7:0]  fv [6];
   logic [7:0]  lo [6];
   logic [7:0]  hi [6];
   logic [7:0]  nx [6];
   logic [5:0]  wrap;
   logic [5:0]  inc;
   logic        hcarry;
   logic [7:0]  hnext;

   // last day of the month, february by leap field
   function automatic logic [7:0] month_end(input logic [7:0] m, input logic [1:0] lp);
      logic [7:0] e;
      e = 8'h31;
      if (m == CCR_FEB) begin
         e = (lp == 2'b00) ? 8'h29 : 8'h28;
      end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
         e = 8'h30;
      end
      return e;
   endfunction : month_end

   // read view of a register, page select and masks applied
   function automatic logic [7:0] read_reg(input logic [13:0] i, input ccr_state_t s);
      logic [7:0] r;
      r = 8'h00;
      case (i)
         CCR_IDX_SEC:   r = s.sec & CCR_SEC_MASK;
         CCR_IDX_MIN:   r = s.min & CCR_SEC_MASK;
         CCR_IDX_HOUR:  r = s.hour & CCR_HOUR_MASK;
         CCR_IDX_WDAY:  r = s.wday & CCR_WDAY_MASK;
         CCR_IDX_MDAY:  r = s.mday & CCR_MDAY_MASK;
         CCR_IDX_MONTH: r = s.page ? {7'h00, s.h24}
                                   : (s.month & CCR_MONTH_MASK);
         CCR_IDX_YEAR:  r = s.page ? {6'h00, s.leap} : s.year;
         CCR_IDX_PAGE:  r = {s.irq_en, 3'b000, s.cnt_en, s.alm_en, 1'b0, s.page};
         CCR_IDX_RESET: r = {s.g1, s.g16, 6'h00};
         CCR_IDX_STAT:  r = {4'h0, s.status};
         CCR_IDX_MASK:  r = {4'h0, s.mask};
         default:       r = 8'h00;
      endcase
      return r;
   endfunction : read_reg

   // sub-second divider
   ccr_prescale #(
      .TICK_CYCLES (TICK_CYCLES)
   ) u_pre (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .clr_i  (s_q.clr),
      .tick_o (tick_w),
      .w1_o   (w1_w),
      .w16_o  (w16_w)
   );

   // bus request decode, one access per ack
   assign req = cyc_i & stb_i & ~s_q.ack;
   assign wr  = req & we_i & sel_i[0];
   assign rd  = req & ~we_i;
   assign idx = adr_i[15:2];

   // per-field bounds; hours use the low five bits in 12-hour mode
   always_comb begin
      fv[0] = s_q.sec;
      fv[1] = s_q.min;
      fv[2] = s_q.h24 ? s_q.hour : {3'b000, s_q.hour[4:0]};
      fv[3] = s_q.mday;
      fv[4] = s_q.month;
      fv[5] = s_q.year;
      lo[0] = 8'h00;
      lo[1] = 8'h00;
      lo[2] = s_q.h24 ? 8'h00 : 8'h01;
      lo[3] = 8'h01;
      lo[4] = 8'h01;
      lo[5] = 8'h00;
      hi[0] = CCR_SEC_MAX;
      hi[1] = CCR_SEC_MAX;
      hi[2] = s_q.h24 ? CCR_H24_MAX : CCR_H12_MAX;
      hi[3] = month_end(s_q.month, s_q.leap);
      hi[4] = CCR_MONTH_MAX;
      hi[5] = CCR_YEAR_MAX;
   end

   // one bcd step per field
   for (genvar g = 0; g < 6; g++) begin : g_step
      ccr_bcd_step u_step (
         .val_i  (fv[g]),
         .min_i  (lo[g]),
         .max_i  (hi[g]),
         .next_o (nx[g]),
         .wrap_o (wrap[g])
      );
   end

   // carry chain; adjust rounds seconds and may carry a minute
   always_comb begin
      inc[0] = tick_w & s_q.cnt_en & ~s_q.adj;
      inc[1] = (inc[0] & wrap[0]) | (s_q.adj & (s_q.sec >= CCR_ADJ_UP));
      inc[2] = inc[1] & wrap[1];
      hcarry = s_q.h24 ? wrap[2] : (s_q.hour[5] & (s_q.hour[4:0] == CCR_H12_LAST));
      inc[3] = inc[2] & hcarry;
      inc[4] = inc[3] & wrap[3];
      inc[5] = inc[4] & wrap[4];
      // 12-hour: 11 to 12 flips the afternoon flag
      if (s_q.h24) begin
         hnext = nx[2];
      end else begin
         hnext = {2'b00, s_q.hour[5] ^ (s_q.hour[4:0] == CCR_H12_LAST), nx[2][4:0]};
      end
   end

   // next state: counting, then bus writes, status, outputs
   always_comb begin
      s_d = s_q;
      s_d.ack = req;
      s_d.clr = 1'b0;
      s_d.adj = 1'b0;
      // counting
      if (inc[0] | s_q.adj) begin
         s_d.sec = s_q.adj ? 8'h00 : nx[0];
      end
      if (inc[1]) begin
         s_d.min = nx[1];
      end
      if (inc[2]) begin
         s_d.hour = hnext;
      end
      if (inc[3]) begin
         s_d.mday = nx[3];
         s_d.wday = (s_q.wday >= CCR_WDAY_MAX) ? 8'h00 : 8'(s_q.wday + 8'h01);
      end
      if (inc[4]) begin
         s_d.month = nx[4];
      end
      if (inc[5]) begin
         s_d.year = nx[5];
         s_d.leap = 2'(s_q.leap + 2'b01);
      end
      // software writes override the count in the same cycle
      if (wr) begin
         case (idx)
            CCR_IDX_SEC:   s_d.sec  = dat_i[7:0] & CCR_SEC_MASK;
            CCR_IDX_MIN:   s_d.min  = dat_i[7:0] & CCR_SEC_MASK;
            CCR_IDX_HOUR:  s_d.hour = dat_i[7:0] & CCR_HOUR_MASK;
            CCR_IDX_WDAY:  s_d.wday = dat_i[7:0] & CCR_WDAY_MASK;
            CCR_IDX_MDAY:  s_d.mday = dat_i[7:0] & CCR_MDAY_MASK;
            CCR_IDX_MONTH: begin
               if (s_q.page) begin
                  s_d.h24 = dat_i[0];
               end else begin
                  s_d.month = dat_i[7:0] & CCR_MONTH_MASK;
               end
            end
            CCR_IDX_YEAR: begin
               if (s_q.page) begin
                  s_d.leap = dat_i[1:0];
               end else begin
                  s_d.year = dat_i[7:0];
               end
            end
            CCR_IDX_PAGE: begin
               s_d.irq_en = dat_i[CCR_PG_IRQ_EN];
               s_d.adj    = dat_i[CCR_PG_ADJ];
               s_d.cnt_en = dat_i[CCR_PG_CNT_EN];
               s_d.alm_en = dat_i[CCR_PG_ALM_EN];
               s_d.page   = dat_i[CCR_PG_SEL];
            end
            CCR_IDX_RESET: begin
               s_d.g1  = dat_i[CCR_RS_1HZ];
               s_d.g16 = dat_i[CCR_RS_16HZ];
               s_d.clr = dat_i[CCR_RS_CLK];
               if (dat_i[CCR_RS_ALM]) begin
                  s_d.alm_en = 1'b0;
               end
            end
            CCR_IDX_MASK:  s_d.mask = dat_i[CCR_ST_W-1:0];
            default: ;
         endcase
      end
      // sticky status: a set wins over the read clear
      s_d.status = ((rd && idx == CCR_IDX_STAT) ? '0 : s_q.status)
                 | {inc[3], inc[2], inc[1], inc[0]};
      s_d.dat = rd ? read_reg(idx, s_q) : 8'h00;
      s_d.irq = s_q.irq_en & (|(s_q.status & s_q.mask));
      s_d.one_hz = s_q.g1 & w1_w;
      s_d.sixteen_hz = s_q.g16 & w16_w;
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
         s_q.mday <= CCR_ONE_RST;
         s_q.month <= CCR_ONE_RST;
         s_q.h24 <= CCR_H24_RST;
         s_q.irq_en <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   assign dat_o        = {24'h00_0000, s_q.dat};
   assign ack_o        = s_q.ack;
   assign irq_o        = s_q.irq;
   assign one_hz_o     = s_q.one_hz;
   assign sixteen_hz_o = s_q.sixteen_hz;

   // checks on the counters and controls
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence s_sec_last;
      tick_w && s_q.cnt_en && !s_q.adj && s_q.sec == 8'h59 && !wr;
   endsequence

   sequence s_adj_low;
      wr && idx == CCR_IDX_PAGE && dat_i[CCR_PG_ADJ] && s_q.sec < 8'h30;
   endsequence

   a_sec_digits: assert property ((inc[0] || s_q.adj) && !wr
      |=> s_q.sec <= 8'h59 && s_q.sec[3:0] <= 4'h9)
      else $error("seconds left bcd range");
   a_min_digits: assert property (inc[1] |=> s_q.min <= 8'h59 && s_q.min[3:0] <= 4'h9)
      else $error("minutes left bcd range");
   a_hour_pm_flip: assert property (inc[2] && !s_q.h24 && s_q.hour[4:0] == 5'h11 && !wr
      |=> s_q.hour[5] != $past(s_q.hour[5]) && s_q.hour[4:0] == 5'h12)
      else $error("12-hour flag did not flip");
   a_mday_read: assert property (rd && idx == CCR_IDX_MDAY |=> ack_o && dat_o[7:6] == 2'b00)
      else $error("day of month upper bits not zero");
   a_month_page: assert property (rd && idx == CCR_IDX_MONTH && s_q.page
      |=> dat_o[7:1] == 7'h00 && dat_o[0] == $past(s_q.h24))
      else $error("hour format bit wrong");
   a_irq_en_reset: assert property ($fell(rst_i) |-> !s_q.irq_en && !irq_o)
      else $error("irq enable not cleared by reset");
   a_adj_round: assert property (s_adj_low |=> s_q.adj ##1 s_q.sec == 8'h00)
      else $error("adjust did not clear seconds");
   a_gate_off: assert property (!s_q.g1 |=> !one_hz_o)
      else $error("1 Hz output not gated");
   a_sec_roll: assert property (s_sec_last |=> s_q.sec == 8'h00 && s_q.min != $past(s_q.min))
      else $error("seconds did not roll into minutes");
   a_feb_leap: assert property (inc[3] && s_q.month == CCR_FEB && s_q.mday == 8'h28 && !wr
      |=> s_q.mday == (($past(s_q.leap) == 2'b00) ? 8'h29 : 8'h01))
      else $error("february end wrong for leap field");
   a_ack_once: assert property (req |=> ack_o ##1 !ack_o)
      else $error("ack not a single cycle");

   // read-back shape, status, irq and prescaler restart
   sequence s_clk_clear;
      wr && idx == CCR_IDX_RESET && dat_i[CCR_RS_CLK];
   endsequence

   a_sec_top_zero: assert property (rd && idx == CCR_IDX_SEC |=> dat_o[7] == 1'b0)
      else $error("seconds top bit not zero");
   a_min_top_zero: assert property (rd && idx == CCR_IDX_MIN |=> dat_o[7] == 1'b0)
      else $error("minutes top bit not zero");
   a_hour_top_zero: assert property (rd && idx == CCR_IDX_HOUR |=> dat_o[7:6] == 2'b00)
      else $error("hours upper bits not zero");
   a_month_top_zero: assert property (rd && idx == CCR_IDX_MONTH && !s_q.page
      |=> dat_o[7:5] == 3'b000)
      else $error("month upper bits not zero");
   a_page_read_zero: assert property (rd && idx == CCR_IDX_PAGE
      |=> dat_o[6:4] == 3'b000 && dat_o[1] == 1'b0)
      else $error("page register unused bits not zero");
   a_irq_level: assert property (s_q.irq_en && (|(s_q.status & s_q.mask)) |=> irq_o)
      else $error("enabled unmasked event did not raise irq");
   a_status_set_wins: assert property (inc[0] |=> s_q.status[CCR_ST_SEC])
      else $error("second event lost from status");
   a_leap_step: assert property (inc[5] && !wr
      |=> s_q.leap == 2'($past(s_q.leap) + 2'b01))
      else $error("leap field did not step with the year");
   a_gate16_off: assert property (!s_q.g16 |=> !sixteen_hz_o)
      else $error("16 Hz output not gated");
   a_clk_restart: assert property (s_clk_clear |=> s_q.clr ##1 !tick_w)
      else $error("clock reset did not restart the divider");
endmodule : ccr_top
`default_nettype wire

// *** rtl/ccr_pkg.sv ***
// Purpose: shared constants for the calendar clock register block
// Assumes: 40 MHz system clock, byte-wide registers on a 32-bit bus
// Notes:   register index times four gives the byte address
`default_nettype none
package ccr_pkg;
   // timing: one prescaler tick is 1/32 s
   localparam int unsigned CCR_CLK_HZ          = 40_000_000;
   localparam int unsigned CCR_TICK_PERIOD_US  = 31_250;
   localparam int unsigned CCR_TICK_CYCLES     = CCR_TICK_PERIOD_US * (CCR_CLK_HZ / 1_000_000);
   localparam int unsigned CCR_TICKS_PER_SEC   = 32;
   // register indexes
   localparam logic [13:0] CCR_IDX_SEC   = 14'h1320;
   localparam logic [13:0] CCR_IDX_MIN   = 14'h1321;
   localparam logic [13:0] CCR_IDX_HOUR  = 14'h1322;
   localparam logic [13:0] CCR_IDX_WDAY  = 14'h1323;
   localparam logic [13:0] CCR_IDX_MDAY  = 14'h1324;
   localparam logic [13:0] CCR_IDX_MONTH = 14'h1325;
   localparam logic [13:0] CCR_IDX_YEAR  = 14'h1326;
   localparam logic [13:0] CCR_IDX_PAGE  = 14'h1327;
   localparam logic [13:0] CCR_IDX_RESET = 14'h1328;
   localparam logic [13:0] CCR_IDX_STAT  = 14'h1329;
   localparam logic [13:0] CCR_IDX_MASK  = 14'h132A;
   // page_control fields
   localparam int unsigned CCR_PG_IRQ_EN = 7;
   localparam int unsigned CCR_PG_ADJ    = 4;
   localparam int unsigned CCR_PG_CNT_EN = 3;
   localparam int unsigned CCR_PG_ALM_EN = 2;
   localparam int unsigned CCR_PG_SEL    = 0;
   // clock_reset_control fields
   localparam int unsigned CCR_RS_1HZ    = 7;
   localparam int unsigned CCR_RS_16HZ   = 6;
   localparam int unsigned CCR_RS_CLK    = 5;
   localparam int unsigned CCR_RS_ALM    = 4;
   // readable bit masks of the count registers
   localparam logic [7:0]  CCR_SEC_MASK   = 8'h7F;
   localparam logic [7:0]  CCR_HOUR_MASK  = 8'h3F;
   localparam logic [7:0]  CCR_WDAY_MASK  = 8'h07;
   localparam logic [7:0]  CCR_MDAY_MASK  = 8'h3F;
   localparam logic [7:0]  CCR_MONTH_MASK = 8'h1F;
   // bcd limits
   localparam logic [7:0]  CCR_SEC_MAX   = 8'h59;
   localparam logic [7:0]  CCR_H24_MAX   = 8'h23;
   localparam logic [7:0]  CCR_H12_MAX   = 8'h12;
   localparam logic [4:0]  CCR_H12_LAST  = 5'h11;
   localparam logic [7:0]  CCR_WDAY_MAX  = 8'h06;
   localparam logic [7:0]  CCR_MONTH_MAX = 8'h12;
   localparam logic [7:0]  CCR_YEAR_MAX  = 8'h99;
   localparam logic [7:0]  CCR_ADJ_UP    = 8'h30;
   localparam logic [7:0]  CCR_FEB       = 8'h02;
   // reset values
   localparam logic [7:0]  CCR_ZERO_RST  = 8'h00;
   localparam logic [7:0]  CCR_ONE_RST   = 8'h01;
   localparam logic        CCR_H24_RST   = 1'b1;
   // interrupt status bits
   localparam int unsigned CCR_ST_W      = 4;
   localparam int unsigned CCR_ST_SEC    = 0;
   localparam int unsigned CCR_ST_MIN    = 1;
   localparam int unsigned CCR_ST_HOUR   = 2;
   localparam int unsigned CCR_ST_DAY    = 3;
endpackage : ccr_pkg
`default_nettype wire

// *** rtl/ccr_bcd_step.sv ***
// Purpose: one bcd counter step with wrap to a lower bound
// Assumes: value in two bcd digits
// Notes:   values at or past the top also wrap, so bad writes recover
`timescale 1ns/10ps
`default_nettype none
module ccr_bcd_step (
   input  wire logic [7:0] val_i,   // present value
   input  wire logic [7:0] min_i,   // value after wrap
   input  wire logic [7:0] max_i,   // last value before wrap
   output logic      [7:0] next_o,  // value after one step
   output logic            wrap_o   // step wraps
);
   // bcd increment with decimal adjust
   always_comb begin
      wrap_o = (val_i >= max_i);
      if (wrap_o) begin
         next_o = min_i;
      end else if (val_i[3:0] >= 4'h9) begin
         next_o = {4'(val_i[7:4] + 4'h1), 4'h0};
      end else begin
         next_o = 8'(val_i + 8'h01);
      end
   end
endmodule : ccr_bcd_step
`default_nettype wire

// *** rtl/ccr_prescale.sv ***
// Purpose: divides the system clock to 16 Hz, 1 Hz waves and a 1 s tick
// Assumes: one clock, synchronous reset
// Notes:   clr_i restarts the sub-second chain
`timescale 1ns/10ps
`default_nettype none
module ccr_prescale
   import ccr_pkg::*;
#(
   parameter int unsigned TICK_CYCLES = CCR_TICK_CYCLES
) (
   input  wire logic clk_i,    // system clock
   input  wire logic rst_i,    // sync reset
   input  wire logic clr_i,    // restart divider
   output logic      tick_o,   // once a second pulse
   output logic      w1_o,     // 1 Hz square wave
   output logic      w16_o     // 16 Hz square wave
);
   typedef struct packed {
      logic [31:0] cnt;
      logic [4:0]  sub;
      logic        tick;
      logic        w1;
      logic        w16;
   } ccr_pre_t;

   ccr_pre_t s_q, s_d;

   // divider chain
   always_comb begin
      s_d = s_q;
      s_d.tick = 1'b0;
      if (s_q.cnt >= TICK_CYCLES - 1) begin
         s_d.cnt = 32'h0000_0000;
         s_d.sub = 5'(s_q.sub + 5'h01);
         s_d.w16 = ~s_q.w16;
         if (s_q.sub[3:0] == 4'hF) begin
            s_d.w1 = ~s_q.w1;
         end
         s_d.tick = (s_q.sub == 5'(CCR_TICKS_PER_SEC - 1));
      end else begin
         s_d.cnt = s_q.cnt + 32'h0000_0001;
      end
      if (clr_i) begin
         s_d = '0;
      end
   end

   // state register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_o = s_q.tick;
   assign w1_o   = s_q.w1;
   assign w16_o  = s_q.w16;
endmodule : ccr_prescale
`default_nettype wire

// *** tb/test_ccr_top.sv ***
// Purpose: self-checking bench for the calendar clock register block
// Assumes: prescaler shortened to 4 clocks a tick, so one second is 128 clocks
// Notes:   every access is a classic wishbone cycle made by the bench
`timescale 1ns/10ps
`default_nettype none
module test_ccr_top;
   import ccr_pkg::*;
   localparam int unsigned TC = 4;
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i  = 1'b0;
   logic [15:0] adr_i = 16'h0000;
   logic [3:0]  sel_i = 4'hF;
   logic [31:0] dat_i = 32'h0000_0000;
   wire logic [31:0] dat_o;
   wire logic        ack_o;
   wire logic        irq_o;
   wire logic        one_hz_o;
   wire logic        sixteen_hz_o;
   logic [7:0]  rdata;
   int          miscompares = 0;
   int          checks = 0;

   ccr_top #(.TICK_CYCLES(TC)) uut (
      .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
      .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .irq_o(irq_o), .one_hz_o(one_hz_o), .sixteen_hz_o(sixteen_hz_o)
   );

   // 40 MHz clock
   always #12.5 clk_i = ~clk_i;

   // verdict and end of run
   task automatic end_sim;
      $display("miscompares %0d checks %0d", miscompares, checks);
      if (miscompares == 0 && checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // one classic cycle, held until ack is sampled high
   task automatic bus(input logic w, input logic [13:0] idx, input logic [7:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i  <= w;
      adr_i <= {idx, 2'b00};
      dat_i <= {24'h00_0000, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack_o !== 1'b1 && n < 50);
      rdata = dat_o[7:0];
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      we_i  <= 1'b0;
      if (ack_o !== 1'b1) begin
         miscompares++;
         $display("ERROR at %0t: no acknowledge", $time);
         end_sim();
      end
   endtask : bus

   task automatic wr(input logic [13:0] idx, input logic [7:0] d);
      bus(1'b1, idx, d);
   endtask : wr

   task automatic rd_chk(input logic [13:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00);
      chk(rdata, exp);
   endtask : rd_chk

   // modes on page one, then the seven count registers on page zero
   task automatic setup(input logic [7:0] h24, input logic [7:0] lp,
                        input logic [7:0] v [0:6]);
      wr(CCR_IDX_PAGE, 8'h01);
      wr(CCR_IDX_MONTH, h24);
      wr(CCR_IDX_YEAR, lp);
      wr(CCR_IDX_PAGE, 8'h00);
      for (int i = 0; i < 7; i++) begin
         wr(CCR_IDX_SEC + 14'(i), v[i]);
      end
   endtask : setup

   task automatic ck_cal(input logic [7:0] e [0:6]);
      for (int i = 0; i < 7; i++) begin
         rd_chk(CCR_IDX_SEC + 14'(i), e[i]);
      end
   endtask : ck_cal

   // restart the prescaler, count for 150 clocks so one second tick lands, then stop
   task automatic tick_run(input logic [7:0] pg);
      wr(CCR_IDX_RESET, 8'h20);
      wr(CCR_IDX_PAGE, pg);
      repeat (150) @(posedge clk_i);
      wr(CCR_IDX_PAGE, pg & 8'h80);
   endtask : tick_run

   // count rising edges of both waves over 300 clocks, a little over two slow periods
   task automatic gate_chk(input logic on1, input logic on16);
      int   r1;
      int   r16;
      logic p1;
      logic p16;
      r1 = 0;
      r16 = 0;
      p1 = one_hz_o;
      p16 = sixteen_hz_o;
      repeat (300) begin
         @(posedge clk_i);
         if (one_hz_o === 1'b1 && p1 === 1'b0) r1++;
         if (sixteen_hz_o === 1'b1 && p16 === 1'b0) r16++;
         p1 = one_hz_o;
         p16 = sixteen_hz_o;
      end
      chk({7'h00, r1 > 0 && r1 < 4}, {7'h00, on1});
      chk({7'h00, r16 > 30}, {7'h00, on16});
   endtask : gate_chk

   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      ck_cal('{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h00});
      rd_chk(CCR_IDX_PAGE, 8'h00);
      rd_chk(CCR_IDX_RESET, 8'h00);
      rd_chk(CCR_IDX_MASK, 8'h00);
      wr(CCR_IDX_PAGE, 8'h01);
      rd_chk(CCR_IDX_MONTH, 8'h01);
      wr(CCR_IDX_YEAR, 8'hFF);
      rd_chk(CCR_IDX_YEAR, 8'h03);
      wr(CCR_IDX_PAGE, 8'h00);
      // unused high bits read back as zero
      for (int i = 0; i < 7; i++) begin
         wr(CCR_IDX_SEC + 14'(i), 8'hFF);
      end
      ck_cal('{8'h7F, 8'h7F, 8'h3F, 8'h07, 8'h3F, 8'h1F, 8'hFF});
      // lane zero off and an unmapped place both leave state alone
      sel_i <= 4'hE;
      wr(CCR_IDX_SEC, 8'h12);
      sel_i <= 4'hF;
      wr(14'h1340, 8'h55);
      rd_chk(CCR_IDX_SEC, 8'h7F);
      rd_chk(14'h1340, 8'h00);
      // page fields, then alarm reset drops alarm enable
      wr(CCR_IDX_PAGE, 8'h85);
      rd_chk(CCR_IDX_PAGE, 8'h85);
      wr(CCR_IDX_RESET, 8'h10);
      rd_chk(CCR_IDX_PAGE, 8'h81);
      // 24-hour, ordinary february, every field but the year steps, irq unmasked
      setup(8'h01, 8'h01, '{8'h59, 8'h59, 8'h23, 8'h06, 8'h28, 8'h02, 8'h23});
      wr(CCR_IDX_MASK, 8'h0F);
      tick_run(8'h88);
      chk({7'h00, irq_o}, 8'h01);
      ck_cal('{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h03, 8'h23});
      rd_chk(CCR_IDX_STAT, 8'h0F);
      repeat (4) @(posedge clk_i);
      chk({7'h00, irq_o}, 8'h00);
      rd_chk(CCR_IDX_STAT, 8'h00);
      // 12-hour 11 pm, leap february, events masked
      setup(8'h00, 8'h00, '{8'h59, 8'h59, 8'h31, 8'h03, 8'h28, 8'h02, 8'h24});
      wr(CCR_IDX_MASK, 8'h00);
      tick_run(8'h88);
      chk({7'h00, irq_o}, 8'h00);
      ck_cal('{8'h00, 8'h00, 8'h12, 8'h04, 8'h29, 8'h02, 8'h24});
      rd_chk(CCR_IDX_STAT, 8'h0F);
      // end of century year steps the leap field back to zero
      setup(8'h00, 8'h03, '{8'h59, 8'h59, 8'h31, 8'h00, 8'h31, 8'h12, 8'h99});
      tick_run(8'h08);
      ck_cal('{8'h00, 8'h00, 8'h12, 8'h01, 8'h01, 8'h01, 8'h00});
      wr(CCR_IDX_PAGE, 8'h01);
      rd_chk(CCR_IDX_YEAR, 8'h00);
      rd_chk(CCR_IDX_MONTH, 8'h00);
      // 11 am rolls into 12 pm without a day carry
      setup(8'h00, 8'h00, '{8'h59, 8'h59, 8'h11, 8'h00, 8'h10, 8'h05, 8'h24});
      tick_run(8'h08);
      ck_cal('{8'h00, 8'h00, 8'h32, 8'h00, 8'h10, 8'h05, 8'h24});
      // adjust rounds seconds, a written zero does nothing
      wr(CCR_IDX_SEC, 8'h30);
      wr(CCR_IDX_MIN, 8'h10);
      wr(CCR_IDX_PAGE, 8'h10);
      rd_chk(CCR_IDX_SEC, 8'h00);
      rd_chk(CCR_IDX_MIN, 8'h11);
      rd_chk(CCR_IDX_PAGE, 8'h00);
      wr(CCR_IDX_SEC, 8'h29);
      wr(CCR_IDX_PAGE, 8'h10);
      rd_chk(CCR_IDX_SEC, 8'h00);
      rd_chk(CCR_IDX_MIN, 8'h11);
      wr(CCR_IDX_SEC, 8'h25);
      wr(CCR_IDX_PAGE, 8'h00);
      rd_chk(CCR_IDX_SEC, 8'h25);
      // output gates
      wr(CCR_IDX_RESET, 8'hC0);
      rd_chk(CCR_IDX_RESET, 8'hC0);
      gate_chk(1'b1, 1'b1);
      wr(CCR_IDX_RESET, 8'h80);
      gate_chk(1'b1, 1'b0);
      wr(CCR_IDX_RESET, 8'h40);
      gate_chk(1'b0, 1'b1);
      wr(CCR_IDX_RESET, 8'h00);
      gate_chk(1'b0, 1'b0);
      end_sim();
   end

   // watchdog against a hung run
   initial begin
      repeat (20000) @(posedge clk_i);
      miscompares++;
      $display("ERROR at %0t: watchdog expired", $time);
      end_sim();
   end
endmodule : test_ccr_top
`default_nettype wire
